//--- mds_muldiv_unit.sv
// Multiply, divide, shift and normalize unit: the device end of the link
`timescale 1ns/1ps
`default_nettype none
`include "mds_consts.svh"

// Contract
// - Core writes operand byte 0 first
// - Byte 2/3 write selects 32/16 division
// - Byte 4 divides 16/16, byte 1 multiplies
// - Byte 5 or control write starts it
// - Unit computes alone after start
// - Latency 17, 9, 11 cycles
// - Shift takes 3 to 18 cycles
// - Normalize takes 3 to 19 cycles
// - Quotient low bytes, remainder bytes 4-5
// - Final read of byte 5/3 ends
// - Normalize shifts left until top bit set
// - Normalize shift total stored in count field
// - Direction bit and nonzero count for shifts
// - Zeros shift in at the vacated end
// - Error detection armed byte 0, disarmed finally
// - Write during execution sets error
// - Operand read during execution sets error, continues
// - Error flag cleared by control read only
// - Overflow: zero divisor, big product, normalized
// - Clean operation clears overflow
// - Software cannot write the overflow flag
// - Zero count selects normalize
// - Overflow visible at control bit 6
module mds_muldiv_unit
  import mds_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  mds_link_if.dev   link,
  output logic      busy_o,
  output logic      err_o,
  output logic      ovf_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Leading zeros of a word, capped at 31 so a zero word still fits the field
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       hit;
    n   = 5'd31;
    hit = 1'b0;
    for (int i = 31; i >= 1; i--) begin
      if (!hit && v[i]) begin
        n   = 5'(31 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // Cycles for a step count: base plus half the count, rounded up
  function automatic logic [4:0] step_lat(input logic [4:0] base, input logic [4:0] n);
    logic [5:0] half;
    half = ({1'b0, n} + 6'd1) >> 1;
    return 5'(base + half[4:0]);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mds_dev_state_e st_q,    st_d;
  mds_op_e        op_q,    op_d;
  logic [7:0]     opb_q    [6];
  logic [7:0]     opb_d    [6];
  logic [4:0]     cnt_f_q, cnt_f_d;    // Shift count field
  logic           dir_q,   dir_d;
  logic           ovf_q,   ovf_d;
  logic           err_q,   err_d;
  logic           armed_q, armed_d;
  logic           hi_q,    hi_d;       // Byte 2/3 seen in load
  logic           b4_q,    b4_d;
  logic           b1_q,    b1_d;
  logic [4:0]     lat_q,   lat_d;
  logic [47:0]    pend_q,  pend_d;     // Result waiting for completion
  logic           pov_q,   pov_d;
  logic [4:0]     pcnt_q,  pcnt_d;
  logic [7:0]     rdata_q, rdata_d;

  logic        wr_ev;
  logic        rd_ev;
  logic [31:0] word_n;
  logic [15:0] divisor_n;
  logic [31:0] prod_n;
  logic [4:0]  lz_n;
  logic [7:0]  actl_n;

  assign wr_ev = ce_i & link.wr;
  assign rd_ev = ce_i & link.rd;

  // Control register as read back; the flags sit above direction and count
  // overflow at bit 6
  assign actl_n = {err_q, ovf_q, dir_q, cnt_f_q};

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    opb_d   = opb_q;
    cnt_f_d = cnt_f_q;
    dir_d   = dir_q;
    ovf_d   = ovf_q;
    err_d   = err_q;
    armed_d = armed_q;
    hi_d    = hi_q;
    b4_d    = b4_q;
    b1_d    = b1_q;
    lat_d   = lat_q;
    pend_d  = pend_q;
    pov_d   = pov_q;
    pcnt_d  = pcnt_q;
    rdata_d = rdata_q;

    if (rd_ev && link.addr == `MDS_ADDR_ACTL) begin
      err_d = 1'b0;
    end

    // Read data and read side effects
    if (rd_ev) begin
      rdata_d = (link.addr == `MDS_ADDR_ACTL) ? actl_n :
                (link.addr <= `MDS_ADDR_OPB5) ? opb_q[link.addr] : 8'h00;
      if (st_q == MDS_ST_EXEC && armed_q && link.addr <= `MDS_ADDR_OPB5) begin
        err_d = 1'b1;
      end
      if (st_q == MDS_ST_RESULT &&
          ((link.addr == `MDS_ADDR_OPB5 &&
            (op_q == MDS_OP_DIV32 || op_q == MDS_OP_DIV16)) ||
           (link.addr == `MDS_ADDR_OPB3 &&
            (op_q == MDS_OP_MUL || op_q == MDS_OP_SHIFT || op_q == MDS_OP_NORM)))) begin
        armed_d = 1'b0;
        st_d    = MDS_ST_IDLE;
      end
    end

    // Completion of an executing calculation
    if (st_q == MDS_ST_EXEC) begin
      if (lat_q == 5'd1) begin
        for (int i = 0; i < 6; i++) begin
          opb_d[i] = pend_q[8*i +: 8];
        end
        ovf_d = pov_q;
        if (op_q == MDS_OP_NORM) begin
          cnt_f_d = pcnt_q;
        end
        st_d = MDS_ST_RESULT;
      end else begin
        lat_d = lat_q - 5'd1;
      end
    end

    // Writes; a write while executing abandons the calculation
    if (wr_ev) begin
      if (st_q == MDS_ST_EXEC) begin
        err_d = 1'b1;
        st_d  = MDS_ST_IDLE;
        opb_d = opb_q;
      end
      if (link.addr <= `MDS_ADDR_OPB5) begin
        opb_d[link.addr] = link.wdata;
      end
      if (link.addr == `MDS_ADDR_ACTL) begin
        dir_d   = link.wdata[`MDS_DIR_BIT];
        cnt_f_d = link.wdata[`MDS_CNT_MSB:0];
      end
      if (link.addr == `MDS_ADDR_OPB0) begin
        armed_d = 1'b1;
        st_d    = MDS_ST_LOAD;
        hi_d    = 1'b0;
        b4_d    = 1'b0;
        b1_d    = 1'b0;
      end else if (st_q == MDS_ST_LOAD) begin
        if (link.addr == `MDS_ADDR_OPB2 || link.addr == `MDS_ADDR_OPB3) begin
          hi_d = 1'b1;
        end
        if (link.addr == `MDS_ADDR_OPB4) begin
          b4_d = 1'b1;
          b1_d = 1'b0;  // Later of bytes 1 and 4 decides
        end
        if (link.addr == `MDS_ADDR_OPB1) begin
          b1_d = 1'b1;
          b4_d = 1'b0;
        end
      end
    end

    // Operand views include the byte written this cycle
    word_n    = {opb_d[3], opb_d[2], opb_d[1], opb_d[0]};
    divisor_n = {opb_d[5], opb_d[4]};
    prod_n    = {opb_d[1], opb_d[0]} * {opb_d[5], opb_d[4]};
    lz_n      = lead_zeros(word_n);

    if (wr_ev && st_q == MDS_ST_LOAD && link.addr == `MDS_ADDR_OPB5) begin
      st_d   = MDS_ST_EXEC;
      pend_d = {opb_d[5], opb_d[4], word_n};
      pov_d  = (divisor_n == 16'h0000);
      if (hi_q) begin
        op_d  = MDS_OP_DIV32;
        lat_d = `MDS_LAT_DIV32;
        if (divisor_n != 16'h0000) begin
          pend_d = {16'(word_n % {16'h0000, divisor_n}), word_n / {16'h0000, divisor_n}};
        end
      end else if (b1_q && !b4_q) begin
        op_d   = MDS_OP_MUL;
        lat_d  = `MDS_LAT_MUL;
        pend_d = {opb_d[5], opb_d[4], prod_n};
        pov_d  = (prod_n > 32'h0000ffff);
      end else begin
        // Only byte 0 written selects the short division too
        op_d  = MDS_OP_DIV16;
        lat_d = `MDS_LAT_DIV16;
        if (divisor_n != 16'h0000) begin
          pend_d = {word_n[15:0] % divisor_n, opb_d[3], opb_d[2], word_n[15:0] / divisor_n};
        end
      end
    end else if (wr_ev && st_q == MDS_ST_LOAD && link.addr == `MDS_ADDR_ACTL) begin
      st_d  = MDS_ST_EXEC;
      pov_d = 1'b0;
      if (link.wdata[`MDS_CNT_MSB:0] == 5'd0) begin
        op_d = MDS_OP_NORM;
        pov_d  = word_n[31];
        pcnt_d = word_n[31] ? 5'd0 : lz_n;
        lat_d  = step_lat(`MDS_LAT_NORM0, pcnt_d);
        pend_d = {opb_d[5], opb_d[4], word_n << pcnt_d};
      end else begin
        op_d  = MDS_OP_SHIFT;
        lat_d = step_lat(`MDS_LAT_SHIFT0, link.wdata[`MDS_CNT_MSB:0]);
        pend_d = {opb_d[5], opb_d[4],
                  link.wdata[`MDS_DIR_BIT] ? word_n >> link.wdata[`MDS_CNT_MSB:0]
                                           : word_n << link.wdata[`MDS_CNT_MSB:0]};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers, frozen while the clock enable is low
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q    <= MDS_ST_IDLE;
      op_q    <= MDS_OP_NONE;
      for (int i = 0; i < 6; i++) begin
        opb_q[i] <= `MDS_BYTE_RESET;
      end
      cnt_f_q <= 5'(`MDS_ACTL_RESET);
      dir_q   <= 1'b0;
      ovf_q   <= 1'b0;
      err_q   <= 1'b0;
      armed_q <= 1'b0;
      hi_q    <= 1'b0;
      b4_q    <= 1'b0;
      b1_q    <= 1'b0;
      lat_q   <= 5'd0;
      pend_q  <= 48'h0;
      pov_q   <= 1'b0;
      pcnt_q  <= 5'd0;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      st_q    <= st_d;
      op_q    <= op_d;
      opb_q   <= opb_d;
      cnt_f_q <= cnt_f_d;
      dir_q   <= dir_d;
      ovf_q   <= ovf_d;
      err_q   <= err_d;
      armed_q <= armed_d;
      hi_q    <= hi_d;
      b4_q    <= b4_d;
      b1_q    <= b1_d;
      lat_q   <= lat_d;
      pend_q  <= pend_d;
      pov_q   <= pov_d;
      pcnt_q  <= pcnt_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign link.rdata = rdata_q;
  assign link.busy  = (st_q == MDS_ST_EXEC);
  assign busy_o     = (st_q == MDS_ST_EXEC);
  assign err_o      = err_q;
  assign ovf_o      = ovf_q;

endmodule
`default_nettype wire

//--- mds_consts.svh
// Address map, field positions, reset values and cycle counts of the arithmetic unit
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

// --------------------------------------------------------------------------
// Register addresses on the link
// --------------------------------------------------------------------------
`define MDS_ADDR_OPB0  3'h0
`define MDS_ADDR_OPB1  3'h1
`define MDS_ADDR_OPB2  3'h2
`define MDS_ADDR_OPB3  3'h3
`define MDS_ADDR_OPB4  3'h4
`define MDS_ADDR_OPB5  3'h5
`define MDS_ADDR_ACTL  3'h6

// --------------------------------------------------------------------------
// Control register fields and reset values
// --------------------------------------------------------------------------
`define MDS_ERR_BIT     7
`define MDS_OVF_BIT     6
`define MDS_DIR_BIT     5
`define MDS_CNT_MSB     4
`define MDS_ACTL_RESET  8'h00
`define MDS_BYTE_RESET  8'h00

// --------------------------------------------------------------------------
// Execution times in clock cycles
// --------------------------------------------------------------------------
`define MDS_LAT_DIV32   5'd17
`define MDS_LAT_DIV16   5'd9
`define MDS_LAT_MUL     5'd11
`define MDS_LAT_SHIFT0  5'd2
`define MDS_LAT_NORM0   5'd3

`endif

//--- mds_pkg.sv
// Types shared by both ends of the arithmetic unit link
package mds_pkg;
  typedef enum logic [2:0] {
    MDS_OP_NONE  = 3'h0,
    MDS_OP_DIV32 = 3'h1,
    MDS_OP_DIV16 = 3'h2,
    MDS_OP_MUL   = 3'h3,
    MDS_OP_SHIFT = 3'h4,
    MDS_OP_NORM  = 3'h5
  } mds_op_e;

  typedef enum logic [1:0] {
    MDS_ST_IDLE   = 2'b00,
    MDS_ST_LOAD   = 2'b01,
    MDS_ST_EXEC   = 2'b11,
    MDS_ST_RESULT = 2'b10
  } mds_dev_state_e;

  typedef enum logic [2:0] {
    MDS_H_IDLE  = 3'b000,
    MDS_H_WRITE = 3'b001,
    MDS_H_WAIT  = 3'b011,
    MDS_H_READ  = 3'b010,
    MDS_H_LAST  = 3'b110
  } mds_host_state_e;
endpackage

//--- mds_link_if.sv
// Register access link between the processor side and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface mds_link_if;
  logic       wr;     // Write strobe, one cycle
  logic       rd;     // Read strobe, one cycle
  logic [2:0] addr;   // Register address
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Read data, valid the cycle after rd
  logic       busy;   // Calculation executing

  modport dev (
    input  wr,
    input  rd,
    input  addr,
    input  wdata,
    output rdata,
    output busy
  );

  modport host (
    output wr,
    output rd,
    output addr,
    output wdata,
    input  rdata,
    input  busy
  );
endinterface
`default_nettype wire

//--- mds_core_end.sv
// Processor-side end: loads operands, waits, reads results back
`timescale 1ns/1ps
`default_nettype none
`include "mds_consts.svh"

module mds_core_end
  import mds_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  mds_link_if.host         link,
  input  wire logic        req_i,
  input  wire mds_op_e     op_i,
  input  wire logic [31:0] opnd_a_i,
  input  wire logic [15:0] opnd_b_i,
  input  wire logic        dir_right_i,
  input  wire logic [4:0]  count_i,
  output logic             idle_o,
  output logic             done_o,
  output logic [31:0]      result_o,
  output logic [15:0]      remainder_o,
  output logic [7:0]       actl_o
);

  // --------------------------------------------------------------------------
  // Sequence tables
  // --------------------------------------------------------------------------
  // Write order per operation; byte 0 always first, starting write last
  function automatic logic [2:0] wr_addr(input mds_op_e op, input logic [2:0] i);
    logic [2:0] a;
    a = 3'(i);
    unique case (op)
      MDS_OP_DIV16: a = (i < 3'd2) ? 3'(i) : 3'(i + 3'd2);
      MDS_OP_MUL:   a = (i == 3'd1) ? `MDS_ADDR_OPB4 :
                        (i == 3'd2) ? `MDS_ADDR_OPB1 :
                        (i == 3'd3) ? `MDS_ADDR_OPB5 : `MDS_ADDR_OPB0;
      MDS_OP_SHIFT,
      MDS_OP_NORM:  a = (i == 3'd4) ? `MDS_ADDR_ACTL : 3'(i);
      default:      a = 3'(i);
    endcase
    return a;
  endfunction

  // Read order: control first, then results, closing read last
  function automatic logic [2:0] rd_addr(input mds_op_e op, input logic [2:0] i);
    logic [2:0] a;
    a = (i == 3'd0) ? `MDS_ADDR_ACTL : 3'(i - 3'd1);
    if (op == MDS_OP_DIV16 && i > 3'd2) begin
      a = 3'(i + 3'd1);
    end
    return a;
  endfunction

  // Index of the last step in either table
  function automatic logic [2:0] last_idx(input mds_op_e op, input logic rd);
    logic [2:0] n;
    unique case (op)
      MDS_OP_DIV32: n = rd ? 3'd6 : 3'd5;
      MDS_OP_DIV16: n = rd ? 3'd4 : 3'd3;
      MDS_OP_MUL:   n = rd ? 3'd4 : 3'd3;
      default:      n = 3'd4;
    endcase
    return n;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mds_host_state_e st_q,   st_d;
  mds_op_e         op_q,   op_d;
  logic [31:0]     a_q,    a_d;
  logic [15:0]     b_q,    b_d;
  logic [7:0]      ctl_q,  ctl_d;     // Control byte to write
  logic [2:0]      idx_q,  idx_d;
  logic [2:0]      paddr_q, paddr_d;  // Address of the read in flight
  logic            pval_q, pval_d;
  logic [47:0]     res_q,  res_d;
  logic [7:0]      actl_q, actl_d;
  logic            done_q, done_d;
  logic            wr_n;
  logic            rd_n;
  logic [2:0]      addr_n;
  logic [7:0]      wdata_n;

  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    a_d     = a_q;
    b_d     = b_q;
    ctl_d   = ctl_q;
    idx_d   = idx_q;
    paddr_d = paddr_q;
    pval_d  = 1'b0;
    res_d   = res_q;
    actl_d  = actl_q;
    done_d  = 1'b0;
    wr_n    = 1'b0;
    rd_n    = 1'b0;
    addr_n  = 3'h0;
    wdata_n = 8'h00;

    // Capture data of the previous read
    if (pval_q) begin
      if (paddr_q == `MDS_ADDR_ACTL) begin
        actl_d = link.rdata;
      end else begin
        res_d[8*paddr_q +: 8] = link.rdata;
      end
    end

    unique case (st_q)
      MDS_H_IDLE: begin
        if (req_i && op_i != MDS_OP_NONE) begin
          op_d  = op_i;
          a_d   = opnd_a_i;
          b_d   = opnd_b_i;
          // zero count never sent for a shift
          ctl_d = {2'b00, dir_right_i,
                   (op_i == MDS_OP_NORM) ? 5'd0 : ((count_i == 5'd0) ? 5'd1 : count_i)};
          idx_d = 3'd0;
          st_d  = MDS_H_WRITE;
        end
      end
      MDS_H_WRITE: begin
        wr_n    = 1'b1;
        addr_n  = wr_addr(op_q, idx_q);
        wdata_n = (addr_n == `MDS_ADDR_ACTL) ? ctl_q :
                  (addr_n >= `MDS_ADDR_OPB4) ? b_q[8*(addr_n - 3'd4) +: 8] : a_q[8*addr_n +: 8];
        if (idx_q == last_idx(op_q, 1'b0)) begin
          st_d = MDS_H_WAIT;
        end else begin
          idx_d = idx_q + 3'd1;
        end
      end
      MDS_H_WAIT: begin
        // No reads while busy, so no error is raised
        if (!link.busy) begin
          idx_d = 3'd0;
          st_d  = MDS_H_READ;
        end
      end
      MDS_H_READ: begin
        rd_n    = 1'b1;
        addr_n  = rd_addr(op_q, idx_q);
        paddr_d = addr_n;
        pval_d  = 1'b1;
        if (idx_q == last_idx(op_q, 1'b1)) begin
          st_d = MDS_H_LAST;
        end else begin
          idx_d = idx_q + 3'd1;
        end
      end
      MDS_H_LAST: begin
        done_d = 1'b1;
        st_d   = MDS_H_IDLE;
      end
      default: st_d = MDS_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q    <= MDS_H_IDLE;
      op_q    <= MDS_OP_NONE;
      a_q     <= 32'h0;
      b_q     <= 16'h0;
      ctl_q   <= 8'h00;
      idx_q   <= 3'd0;
      paddr_q <= 3'd0;
      pval_q  <= 1'b0;
      res_q   <= 48'h0;
      actl_q  <= 8'h00;
      done_q  <= 1'b0;
    end else if (ce_i) begin
      st_q    <= st_d;
      op_q    <= op_d;
      a_q     <= a_d;
      b_q     <= b_d;
      ctl_q   <= ctl_d;
      idx_q   <= idx_d;
      paddr_q <= paddr_d;
      pval_q  <= pval_d;
      res_q   <= res_d;
      actl_q  <= actl_d;
      done_q  <= done_d;
    end
  end

  // Strobes are gated so a frozen host issues nothing
  assign link.wr     = wr_n & ce_i;
  assign link.rd     = rd_n & ce_i;
  assign link.addr   = addr_n;
  assign link.wdata  = wdata_n;
  assign idle_o      = (st_q == MDS_H_IDLE);
  assign done_o      = done_q;
  assign result_o    = res_q[31:0];
  assign remainder_o = res_q[47:32];
  assign actl_o      = actl_q;

endmodule
`default_nettype wire

//--- mds_link_props_props.sv
// Concurrent checks on the link between the processor end and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module mds_link_props
  import mds_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       busy
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // --------------------------------------------------------------------------
  // Helper state
  // --------------------------------------------------------------------------
  logic [4:0] cnt_q;    // Busy cycles so far
  logic [4:0] lat_q;    // Expected shift time
  logic       armed_q;  // Between first write and final read
  mds_op_e    op_q;

  // Latest of bytes 1/4 decides unless 2/3 seen; count busy cycles
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 5'h00;
      lat_q <= 5'h00;
      armed_q <= 1'b0;
      op_q <= MDS_OP_NONE;
    end else begin
      cnt_q <= busy ? cnt_q + 5'h01 : 5'h00;
      if (wr && addr == 3'h0) op_q <= MDS_OP_DIV16;
      if (wr && (addr == 3'h2 || addr == 3'h3)) op_q <= MDS_OP_DIV32;
      if (wr && addr == 3'h1 && op_q != MDS_OP_DIV32) op_q <= MDS_OP_MUL;
      if (wr && addr == 3'h4 && op_q != MDS_OP_DIV32) op_q <= MDS_OP_DIV16;
      if (wr && addr == 3'h6) op_q <= (wdata[4:0] == 5'h00) ? MDS_OP_NORM : MDS_OP_SHIFT;
      if (wr && addr == 3'h6) lat_q <= 5'(6'd2 + ({1'b0, wdata[4:0]} + 6'd1) / 6'd2);
      if (wr && addr == 3'h0) armed_q <= 1'b1;
      // Division closes on byte 5, the others on byte 3
      if (rd && addr == ((op_q == MDS_OP_DIV32 || op_q == MDS_OP_DIV16) ? 3'h5 : 3'h3))
        armed_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence start_s;
    wr && armed_q && (addr == 3'h5 || addr == 3'h6) && !busy;
  endsequence
  sequence done_s;
    $fell(busy);
  endsequence

  chk_start_busy: assert property (start_s |=> busy)
    else $error("busy missing after start");
  chk_div32_len: assert property (done_s ##0 op_q == MDS_OP_DIV32 |-> cnt_q == 5'd17)
    else $error("wide division time wrong");
  chk_div16_len: assert property (done_s ##0 op_q == MDS_OP_DIV16 |-> cnt_q == 5'd9)
    else $error("narrow division time wrong");
  chk_mul_len: assert property (done_s ##0 op_q == MDS_OP_MUL |-> cnt_q == 5'd11)
    else $error("multiply time wrong");
  chk_shift_len: assert property (done_s ##0 op_q == MDS_OP_SHIFT |-> cnt_q == lat_q)
    else $error("shift time wrong");
  chk_norm_len: assert property (done_s ##0 op_q == MDS_OP_NORM |-> cnt_q inside {[5'd3:5'd19]})
    else $error("normalize time out of range");
  chk_busy_quiet: assert property (busy |-> !wr && !rd)
    else $error("access while busy");
  chk_first_write: assert property (wr && !armed_q |-> addr == 3'h0)
    else $error("sequence not opened by byte 0");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench: both link ends joined, plus a bench-driven unit for fault cases
`timescale 1ns/1ps
`default_nettype none
module tb
  import mds_pkg::*;
;
  typedef struct packed {
    logic [31:0] res;
    logic [31:0] rmsk;
    logic [15:0] rem;
    logic [15:0] qmsk;
    logic [7:0]  ctl;
    logic [7:0]  cmsk;
  } mds_exp_s;

  logic        ref_clk_i;
  logic        reset_n_i;
  logic        req;
  mds_op_e     op;
  logic [31:0] opa;
  logic [15:0] opb;
  logic        dir_r;
  logic [4:0]  cnt;
  logic        idle;
  logic        done;
  logic [31:0] res;
  logic [15:0] rem;
  logic [7:0]  actl;
  logic        err2;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  mds_exp_s    exp_q[$];
  mds_exp_s    e;

  mds_link_if link ();
  mds_link_if if2 ();

  mds_muldiv_unit mds_muldiv_unit_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .ce_i(1'b1), .link(link), .busy_o(), .err_o(), .ovf_o());
  mds_core_end mds_core_end_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .link(link), .req_i(req), .op_i(op), .opnd_a_i(opa), .opnd_b_i(opb), .dir_right_i(dir_r),
    .count_i(cnt), .idle_o(idle), .done_o(done), .result_o(res), .remainder_o(rem),
    .actl_o(actl));
  // Second unit: the bench breaks the access rules on purpose
  mds_muldiv_unit mds_muldiv_unit_inst_b (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .ce_i(1'b1), .link(if2), .busy_o(), .err_o(err2), .ovf_o());
  mds_link_props mds_link_props_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .wr(link.wr), .rd(link.rd), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .busy(link.busy));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reference result; masks hide bytes a job does not read back
  function automatic mds_exp_s exp_of(input mds_op_e o, input logic [31:0] a,
                                      input logic [15:0] b, input logic d, input logic [4:0] c);
    mds_exp_s    x;
    logic [31:0] p;
    int          n;
    x = '0;
    x.cmsk = 8'hc0;
    x.rmsk = 32'hffffffff;
    p = (o == MDS_OP_DIV16) ? {16'h0000, a[15:0]} : a;
    n = 0;
    case (o)
      MDS_OP_DIV32, MDS_OP_DIV16: begin
        if (o == MDS_OP_DIV16) x.rmsk = 32'h0000ffff;
        x.qmsk = 16'hffff;
        x.ctl[6] = (b == 16'h0000);
        x.res = x.ctl[6] ? p : p / b;
        x.rem = x.ctl[6] ? b : 16'(p % b);
      end
      MDS_OP_MUL: begin
        x.res = a[15:0] * b;
        x.ctl[6] = (x.res > 32'h0000ffff);
      end
      MDS_OP_SHIFT: begin
        x.res = d ? a >> c : a << c;
        x.ctl = {2'b00, d, c};
        x.cmsk = 8'hff;
      end
      default: begin
        while (n < 31 && a[31 - n] == 1'b0) n++;
        x.res = a << n;
        x.ctl = {1'b0, a[31], d, 5'(n)};
        x.cmsk = 8'hff;
      end
    endcase
    return x;
  endfunction

  // One host job; inputs held until the next job
  task automatic run(input mds_op_e o, input logic [31:0] a, input logic [15:0] b,
                     input logic d, input logic [4:0] c);
    while (idle !== 1'b1) @(negedge ref_clk_i);
    exp_q.push_back(exp_of(o, a, b, d, c));
    op = o;
    opa = a;
    opb = b;
    dir_r = d;
    cnt = c;
    req = 1'b1;
    @(negedge ref_clk_i);
    req = 1'b0;
  endtask

  // One strobe on the second link; lines show a changed value when idle
  task automatic lk(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    if2.wr = w;
    if2.rd = r;
    if2.addr = a;
    if2.wdata = d;
    @(negedge ref_clk_i);
    if2.wr = 1'b0;
    if2.rd = 1'b0;
    if2.addr = ~a;
    if2.wdata = ~d;
  endtask

  // --------------------------------------------------------------------------
  // Clock, watchdog and result monitor
  // --------------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // About 40 jobs of under 40 cycles each
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  // Oldest note against each finished job
  always @(negedge ref_clk_i) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      check(res & e.rmsk, e.res & e.rmsk);
      check(rem & e.qmsk, e.rem & e.qmsk);
      check(actl & e.cmsk, e.ctl & e.cmsk);
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    req = 1'b0;
    op = MDS_OP_NONE;
    opa = 32'h00000000;
    opb = 16'h0000;
    dir_r = 1'b0;
    cnt = 5'h01;
    if2.wr = 1'b0;
    if2.rd = 1'b0;
    if2.addr = 3'h7;
    if2.wdata = 8'h00;
    void'($urandom(32'h06b7));
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    // Zero divisor, then a clean job clearing overflow
    run(MDS_OP_DIV32, $urandom, 16'h0000, 1'b0, 5'h01);
    run(MDS_OP_DIV16, 32'h00000064, 16'h0007, 1'b0, 5'h01);
    run(MDS_OP_MUL, 32'h0000ffff, 16'hffff, 1'b0, 5'h01);
    run(MDS_OP_MUL, 32'h000000ff, 16'h0100, 1'b0, 5'h01);
    run(MDS_OP_SHIFT, $urandom, 16'h0000, 1'b1, 5'h1f);
    run(MDS_OP_SHIFT, $urandom, 16'h0000, 1'b0, 5'h01);
    run(MDS_OP_NORM, 32'h00000000, 16'h0000, 1'b0, 5'h00);
    run(MDS_OP_NORM, 32'h80000001, 16'h0000, 1'b0, 5'h00);
    run(MDS_OP_NORM, 32'h00000001, 16'h0000, 1'b0, 5'h00);
    repeat (30) run(mds_op_e'(3'(1 + $urandom % 5)), $urandom, 16'($urandom),
                    1'($urandom), 5'(1 + $urandom % 31));
    while (exp_q.size() != 0) @(negedge ref_clk_i);
    // Read during a multiply: flag set, result still arrives
    lk(1'b1, 1'b0, 3'h0, 8'h05);
    lk(1'b1, 1'b0, 3'h4, 8'h03);
    lk(1'b1, 1'b0, 3'h1, 8'h00);
    lk(1'b1, 1'b0, 3'h5, 8'h00);
    lk(1'b0, 1'b1, 3'h0, 8'h00);
    check(err2, 1'b1);
    while (if2.busy === 1'b1) @(negedge ref_clk_i);
    lk(1'b0, 1'b1, 3'h0, 8'h00);
    check(if2.rdata, 8'h0f);
    lk(1'b1, 1'b0, 3'h6, 8'h41);
    lk(1'b0, 1'b1, 3'h6, 8'h00);
    check(if2.rdata, 8'h81);
    check(err2, 1'b0);
    // Write in mid-calculation aborts it
    lk(1'b1, 1'b0, 3'h0, 8'h64);
    lk(1'b1, 1'b0, 3'h4, 8'h07);
    lk(1'b1, 1'b0, 3'h5, 8'h00);
    lk(1'b1, 1'b0, 3'h0, 8'h00);
    check(err2, 1'b1);
    @(negedge ref_clk_i);
    check(if2.busy, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
